// ---- hw/ampcsb_pkg.sv ----
package ampcsb_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_BYTES = 4;
  // Seven-bit bus address: base plus strap offsets
  localparam logic [6:0] ADDR_BASE = 7'h20;
  localparam int ADDR_MOD_SHIFT = 3;
  localparam logic [1:0] STRAP_GROUNDED = 2'h0;
  localparam logic [3:0] STRAP_SETTLE = 4'h8;
  // Bit positions shared by configuration and status bytes
  localparam int B0 = 0;
  localparam int B1 = 1;
  localparam int B2 = 2;
  localparam int B3 = 3;
  localparam int B4 = 4;
  localparam int B5 = 5;
  localparam int B6 = 6;
  localparam int B7 = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS1_RESET = 8'h80;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    S_IDLE      = 3'b000,
    S_ADDR      = 3'b001,
    S_ADDR_ACK  = 3'b010,
    S_WRITE     = 3'b011,
    S_WRITE_ACK = 3'b100,
    S_READ      = 3'b101,
    S_READ_ACK  = 3'b110
  } ampcsb_state_type;
endpackage

// ---- hw/ampcsb_bank.sv ----
// Summary of operation
// - Write transfer fills configuration bytes one to four in order.
// - Power-on reset clears all configuration bits.
// - Byte1 D0 standby/operate; byte2 D0 mutes all channels.
// - Byte1 D7 offset report on diagnostic pin; byte2 D7 offset protection.
// - Byte n D6 offset monitor, D5 clip to diagnostic, D1 channel enable.
// - Byte1 D3 oscillator minus/plus ten percent; D4 frequency hopping.
// - Byte2 D4 thermal prewarning report; D3 picks 140 or 120 degrees.
// - Byte1 D2 AC-load detection; byte2 D2 DC-load detection.
// - Byte3 D3 selects one or two ohm shorted-load threshold.
// - Byte4 D3:D2 set slave oscillator phase offset.
// - Read transfer returns status bytes one to four in order.
// - Short, offset, temperature and supply flags latch once set.
// - Finished read clears status except DC-load bits, valid bit and the all-zero bit.
// - Status1 D6 shows DC-load results valid.
// - Status byte n D4 open load, D3 shorted load.
// - Status byte n D1 short to supply, D0 short to ground.
// - D2 reports offset, PLL lock, clock failure, start-up busy.
// - Status1 D7 set when all config zero; then diagnostic pin low.
// - Straps choose one of twelve addresses; grounded strap disables bus.
// - Byte3 D4 selects clip threshold 0.2 or 10 percent.
`timescale 1ns/1ps
module ampcsb_bank
  import ampcsb_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          sclIn,
  input  wire logic                          sdaIn,
  output logic                               sdaOut,
  output logic                               sdaOe,
  input  wire logic [1:0]                    address_strap_a,
  input  wire logic [1:0]                    modeStrap,
  input  wire logic [ampcsb_pkg::NUM_CH-1:0] shortGnd,
  input  wire logic [ampcsb_pkg::NUM_CH-1:0] shortSupply,
  input  wire logic [ampcsb_pkg::NUM_CH-1:0] openLoad,
  input  wire logic [ampcsb_pkg::NUM_CH-1:0] shortedLoad,
  input  wire logic [ampcsb_pkg::NUM_CH-1:0] clipActive,
  input  wire logic                          dcLoadValid,
  input  wire logic                          offsetDetected,
  input  wire logic                          pllLocked,
  input  wire logic                          clockFailure,
  input  wire logic                          startupBusy,
  input  wire logic                          overTemp,
  input  wire logic                          tempWarn,
  input  wire logic                          undervoltage_flag,
  input  wire logic                          overvoltage_flag,
  input  wire logic                          acLoadHit,
  output logic                               busMode,
  output logic                               ampOn,
  output logic                               muteAll,
  output logic [ampcsb_pkg::NUM_CH-1:0]      chanEnable,
  output logic [ampcsb_pkg::NUM_CH-1:0]      offsetMonitorOn,
  output logic [ampcsb_pkg::NUM_CH-1:0]      clipToDiag,
  output logic                               offsetDiagOn,
  output logic                               offsetProtectOn,
  output logic                               oscPlusTen,
  output logic                               freqHopOn,
  output logic                               thermalDiagOn,
  output logic                               warnAt120,
  output logic                               acLoadDetOn,
  output logic                               dcLoadDetOn,
  output logic                               clipAtTen,
  output logic                               shortAtTwoOhm,
  output logic [1:0]                         slavePhase,
  output logic                               diagnostic_pinOut,
  output logic                               diagnostic_pinOe
);
  import ampcsb_pkg::*;

  // Pin synchronisers
  logic [1:0] sclSync_reg;
  logic [1:0] sdaSync_reg;
  logic [3:0] strapSync1_reg;
  logic [3:0] strapSync2_reg;
  logic       sclPrev_reg;
  logic       sdaPrev_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclSync_reg    <= 2'h3;
      sdaSync_reg    <= 2'h3;
      strapSync1_reg <= 4'h0;
      strapSync2_reg <= 4'h0;
      sclPrev_reg    <= 1'b1;
      sdaPrev_reg    <= 1'b1;
    end
    else
    begin
      sclSync_reg    <= {sclSync_reg[0], sclIn};
      sdaSync_reg    <= {sdaSync_reg[0], sdaIn};
      strapSync1_reg <= {modeStrap, address_strap_a};
      strapSync2_reg <= strapSync1_reg;
      sclPrev_reg    <= sclSync_reg[1];
      sdaPrev_reg    <= sdaSync_reg[1];
    end
  end

  logic scl;
  logic sda;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign scl       = sclSync_reg[1];
  assign sda       = sdaSync_reg[1];
  assign sclRise   = scl && !sclPrev_reg;
  assign sclFall   = !scl && sclPrev_reg;
  assign startCond = scl && sclPrev_reg && sdaPrev_reg && !sda;
  assign stopCond  = scl && sclPrev_reg && !sdaPrev_reg && sda;

  // Strap capture after reset release
  logic [3:0] strapCnt_reg;
  logic [3:0] strapCnt_next;
  logic [6:0] devAddr_reg;
  logic [6:0] devAddr_next;
  logic       busMode_reg;
  logic       busMode_next;

  always_comb
  begin
    strapCnt_next = strapCnt_reg;
    devAddr_next  = devAddr_reg;
    busMode_next  = busMode_reg;
    if (strapCnt_reg != STRAP_SETTLE)
    begin
      strapCnt_next = strapCnt_reg + 4'h1;
      if (strapCnt_reg == STRAP_SETTLE - 4'h1)
      begin
        busMode_next = (strapSync2_reg[1:0] != STRAP_GROUNDED);
        devAddr_next = ADDR_BASE + {2'h0, strapSync2_reg[3:2], 3'h0}
                     + {5'h00, strapSync2_reg[1:0]} - 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strapCnt_reg <= 4'h0;
      devAddr_reg  <= ADDR_BASE;
      busMode_reg  <= 1'b0;
    end
    else
    begin
      strapCnt_reg <= strapCnt_next;
      devAddr_reg  <= devAddr_next;
      busMode_reg  <= busMode_next;
    end
  end

  // Bus protocol engine and configuration bytes
  ampcsb_state_type state_reg;
  ampcsb_state_type state_next;
  logic [3:0]       bitCnt_reg;
  logic [3:0]       bitCnt_next;
  logic [1:0]       byteIdx_reg;
  logic [1:0]       byteIdx_next;
  logic [2:0]       byteCnt_reg;
  logic [2:0]       byteCnt_next;
  logic [7:0]       shiftIn_reg;
  logic [7:0]       shiftIn_next;
  logic [7:0]       shiftOut_reg;
  logic [7:0]       shiftOut_next;
  logic             sdaLow_reg;
  logic             sdaLow_next;
  logic             masterAck_reg;
  logic             masterAck_next;
  logic             readDone_reg;
  logic             readDone_next;
  logic             clearStatus;
  logic [7:0]       config_reg [NUM_BYTES];
  logic [7:0]       config_next [NUM_BYTES];
  logic [7:0]       status_reg [NUM_BYTES];
  logic [7:0]       status_next [NUM_BYTES];

  always_comb
  begin
    state_next     = state_reg;
    bitCnt_next    = bitCnt_reg;
    byteIdx_next   = byteIdx_reg;
    byteCnt_next   = byteCnt_reg;
    shiftIn_next   = shiftIn_reg;
    shiftOut_next  = shiftOut_reg;
    sdaLow_next    = sdaLow_reg;
    masterAck_next = masterAck_reg;
    readDone_next  = readDone_reg;
    clearStatus    = 1'b0;
    for (int i = 0; i < NUM_BYTES; i++)
    begin
      config_next[i] = config_reg[i];
    end
    if (startCond || stopCond)
    begin
      clearStatus   = readDone_reg;
      readDone_next = 1'b0;
      sdaLow_next   = 1'b0;
      bitCnt_next   = 4'h0;
      state_next    = (startCond && busMode_reg) ? S_ADDR : S_IDLE;
    end
    else if (sclRise)
    begin
      if (state_reg == S_ADDR || state_reg == S_WRITE)
      begin
        shiftIn_next = {shiftIn_reg[6:0], sda};
        bitCnt_next  = bitCnt_reg + 4'h1;
      end
      else if (state_reg == S_READ)
      begin
        bitCnt_next = bitCnt_reg + 4'h1;
      end
      else if (state_reg == S_READ_ACK)
      begin
        masterAck_next = !sda;
      end
    end
    else if (sclFall)
    begin
      case (state_reg)
        S_ADDR:
        begin
          if (bitCnt_reg == BITS_PER_BYTE)
          begin
            if (shiftIn_reg[7:1] == devAddr_reg)
            begin
              state_next  = S_ADDR_ACK;
              sdaLow_next = 1'b1;
            end
            else
            begin
              state_next = S_IDLE;
            end
          end
        end
        S_ADDR_ACK:
        begin
          bitCnt_next  = 4'h0;
          byteIdx_next = 2'h0;
          byteCnt_next = 3'h0;
          if (shiftIn_reg[B0])
          begin
            state_next    = S_READ;
            shiftOut_next = status_reg[0];
            sdaLow_next   = !status_reg[0][B7];
          end
          else
          begin
            state_next  = S_WRITE;
            sdaLow_next = 1'b0;
          end
        end
        S_WRITE:
        begin
          if (bitCnt_reg == BITS_PER_BYTE)
          begin
            if (byteCnt_reg < 3'(NUM_BYTES))
            begin
              state_next  = S_WRITE_ACK;
              sdaLow_next = 1'b1;
            end
            else
            begin
              state_next = S_IDLE;
            end
          end
        end
        S_WRITE_ACK:
        begin
          config_next[byteIdx_reg] = shiftIn_reg;
          byteIdx_next = byteIdx_reg + 2'h1;
          byteCnt_next = byteCnt_reg + 3'h1;
          bitCnt_next  = 4'h0;
          sdaLow_next  = 1'b0;
          state_next   = S_WRITE;
        end
        S_READ:
        begin
          readDone_next = 1'b1;
          if (bitCnt_reg == BITS_PER_BYTE)
          begin
            sdaLow_next = 1'b0;
            state_next  = S_READ_ACK;
          end
          else
          begin
            shiftOut_next = {shiftOut_reg[6:0], 1'b0};
            sdaLow_next   = !shiftOut_reg[B6];
          end
        end
        S_READ_ACK:
        begin
          bitCnt_next = 4'h0;
          if (masterAck_reg)
          begin
            byteIdx_next  = byteIdx_reg + 2'h1;
            byteCnt_next  = byteCnt_reg + 3'h1;
            shiftOut_next = (byteCnt_reg < 3'(NUM_BYTES - 1)) ? status_reg[byteIdx_reg + 2'h1] : IDLE_BYTE;
            sdaLow_next   = (byteCnt_reg < 3'(NUM_BYTES - 1)) ? !status_reg[byteIdx_reg + 2'h1][B7] : 1'b0;
            state_next    = S_READ;
          end
          else
          begin
            state_next = S_IDLE;
          end
        end
        default:
        begin
          state_next = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg     <= S_IDLE;
      bitCnt_reg    <= 4'h0;
      byteIdx_reg   <= 2'h0;
      byteCnt_reg   <= 3'h0;
      shiftIn_reg   <= 8'h00;
      shiftOut_reg  <= 8'h00;
      sdaLow_reg    <= 1'b0;
      masterAck_reg <= 1'b0;
      readDone_reg  <= 1'b0;
      for (int i = 0; i < NUM_BYTES; i++)
      begin
        config_reg[i] <= CONFIG_RESET;
      end
    end
    else
    begin
      state_reg     <= state_next;
      bitCnt_reg    <= bitCnt_next;
      byteIdx_reg   <= byteIdx_next;
      byteCnt_reg   <= byteCnt_next;
      shiftIn_reg   <= shiftIn_next;
      shiftOut_reg  <= shiftOut_next;
      sdaLow_reg    <= sdaLow_next;
      masterAck_reg <= masterAck_next;
      readDone_reg  <= readDone_next;
      for (int i = 0; i < NUM_BYTES; i++)
      begin
        config_reg[i] <= config_next[i];
      end
    end
  end

  // Status bytes: sticky flags, set wins over the read clear
  logic       allZero;
  logic [3:0] byteD2Event;
  assign allZero     = ~|{config_reg[0], config_reg[1], config_reg[2], config_reg[3]};
  assign byteD2Event = {startupBusy, clockFailure, pllLocked, offsetDetected};

  always_comb
  begin
    for (int i = 0; i < NUM_BYTES; i++)
    begin
      status_next[i]     = status_reg[i] & {8{!clearStatus}};
      status_next[i][B0] = status_next[i][B0] | shortGnd[i];
      status_next[i][B1] = status_next[i][B1] | shortSupply[i];
      status_next[i][B2] = status_next[i][B2] | byteD2Event[i];
      status_next[i][B3] = shortedLoad[i];
      status_next[i][B4] = openLoad[i];
    end
    status_next[0][B5] = status_next[0][B5] | overvoltage_flag;
    status_next[0][B6] = dcLoadValid;
    status_next[0][B7] = allZero;
    status_next[1][B5] = status_next[1][B5] | undervoltage_flag;
    status_next[1][B6] = status_next[1][B6] | tempWarn;
    status_next[1][B7] = status_next[1][B7] | overTemp;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_reg[0] <= STATUS1_RESET;
      for (int i = 1; i < NUM_BYTES; i++)
      begin
        status_reg[i] <= STATUS_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_BYTES; i++)
      begin
        status_reg[i] <= status_next[i];
      end
    end
  end

  // Configuration decode
  always_comb
  begin
    ampOn           = config_reg[0][B0];
    muteAll         = config_reg[1][B0];
    offsetDiagOn    = !config_reg[0][B7];
    offsetProtectOn = !config_reg[1][B7];
    oscPlusTen      = config_reg[0][B3];
    freqHopOn       = config_reg[0][B4];
    thermalDiagOn   = !config_reg[1][B4];
    warnAt120       = config_reg[1][B3];
    acLoadDetOn     = config_reg[0][B2];
    dcLoadDetOn     = config_reg[1][B2];
    shortAtTwoOhm   = config_reg[2][B3];
    clipAtTen       = config_reg[2][B4];
    slavePhase      = config_reg[3][B3:B2];
    for (int i = 0; i < NUM_CH; i++)
    begin
      offsetMonitorOn[i] = !config_reg[i][B6];
      clipToDiag[i]      = !config_reg[i][B5];
      chanEnable[i]      = !config_reg[i][B1];
    end
  end

  // Diagnostic pin, open drain, pulled low on all-zero config, supply, temperature, short, offset, and clip or, in AC-load detection, AC-load conditions
  logic diagLow_reg;
  logic diagLow_next;

  always_comb
  begin
    diagLow_next = status_reg[0][B7]
                 | undervoltage_flag | overvoltage_flag | overTemp
                 | (|shortGnd) | (|shortSupply)
                 | (offsetDiagOn & offsetDetected)
                 | (thermalDiagOn & tempWarn)
                 | (acLoadDetOn ? acLoadHit : |(clipActive & clipToDiag));
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      diagLow_reg <= 1'b1;
    end
    else
    begin
      diagLow_reg <= diagLow_next;
    end
  end

  assign diagnostic_pinOut = 1'b0;
  assign diagnostic_pinOe  = diagLow_reg;
  assign sdaOut            = 1'b0;
  assign sdaOe             = sdaLow_reg;
  assign busMode           = busMode_reg;
endmodule

// ---- tb/ampcsb_bank_asserts.sv ----
`timescale 1ns/1ps
module ampcsb_bank_asserts
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [3:0] shortGnd,
  input wire logic [3:0] shortSupply,
  input wire logic       undervoltage_flag,
  input wire logic       overvoltage_flag,
  input wire logic       busMode,
  input wire logic       ampOn,
  input wire logic       muteAll,
  input wire logic [3:0] chanEnable,
  input wire logic [1:0] slavePhase,
  input wire logic       diagnostic_pinOut,
  input wire logic       diagnostic_pinOe
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Pin register alone: one edge from a sampled fault
  sequence diagSoon;
    ##[1:3] diagnostic_pinOe;
  endsequence
  // The pin follows live faults; only the status bytes keep them
  sequence shortHeld;
    (|shortGnd || |shortSupply) [*4];
  endsequence
  sequence oeSteady;
    $stable(sdaOe) [*8];
  endsequence

  a_pins_open_drain:
    assert property (!sdaOut && !diagnostic_pinOut) else $error("open-drain pin driven high");
  a_diagnostic_pin_on_short:
    assert property ((|shortGnd || |shortSupply) |-> diagSoon) else $error("short not shown on diagnostic_pin pin");
  a_diagnostic_pin_on_supply:
    assert property ((overvoltage_flag || undervoltage_flag) |-> diagSoon) else $error("supply fault not on diagnostic_pin");
  a_diagnostic_pin_while_short:
    assert property (shortHeld |=> diagnostic_pinOe) else $error("diagnostic_pin pin released while short present");
  a_oe_steady_high:
    assert property ($rose(sclIn) |-> oeSteady) else $error("data pin changed while bus clock high");
  a_cfg_at_low:
    assert property ($changed({ampOn, muteAll, chanEnable, slavePhase}) |-> !sclIn)
      else $error("config applied while bus clock high");
  a_off_bus_quiet:
    assert property (!busMode |-> !sdaOe) else $error("data pin pulled outside bus mode");
  a_bus_mode_held:
    assert property (busMode |=> busMode) else $error("bus mode dropped after strap latch");
endmodule

bind ampcsb_bank ampcsb_bank_asserts u_checker
(
  .clk               (clk),
  .reset_n           (reset_n),
  .sclIn             (sclIn),
  .sdaOut            (sdaOut),
  .sdaOe             (sdaOe),
  .shortGnd          (shortGnd),
  .shortSupply       (shortSupply),
  .undervoltage_flag (undervoltage_flag),
  .overvoltage_flag  (overvoltage_flag),
  .busMode           (busMode),
  .ampOn             (ampOn),
  .muteAll           (muteAll),
  .chanEnable        (chanEnable),
  .slavePhase        (slavePhase),
  .diagnostic_pinOut (diagnostic_pinOut),
  .diagnostic_pinOe  (diagnostic_pinOe)
);

// ---- tb/ampcsb_i2c_master.sv ----
`timescale 1ns/1ps
module ampcsb_i2c_master
(
  output logic      sclOut,
  output logic      sdaDrive,
  input  wire logic sdaLine
);
  // Quarter of the 125 ns bus clock period
  localparam real QUARTER = 31.25;

  initial
  begin
    sclOut   = 1'b1;
    sdaDrive = 1'b1;
  end

  task automatic startCond();
    sdaDrive = 1'b1;
    #QUARTER sclOut = 1'b1;
    #QUARTER sdaDrive = 1'b0;
    #QUARTER sclOut = 1'b0;
    #QUARTER;
  endtask

  task automatic stopCond();
    sdaDrive = 1'b0;
    #QUARTER sclOut = 1'b1;
    #QUARTER sdaDrive = 1'b1;
    #QUARTER;
  endtask

  // Eight data bits then the acknowledge bit; a 1 releases the line to its pull-up
  task automatic xfer(input logic [7:0] txByte, input logic ackIn, output logic [7:0] rxByte,
                      output logic ackSeen);
    logic [8:0] frame;
    frame = {txByte, ackIn};
    for (int i = 8; i >= 0; i--)
    begin
      sdaDrive = frame[i];
      #QUARTER sclOut = 1'b1;
      #QUARTER frame[i] = sdaLine;
      #QUARTER sclOut = 1'b0;
      #QUARTER;
    end
    rxByte  = frame[8:1];
    ackSeen = frame[0];
  endtask
endmodule

// ---- tb/ampcsb_bank_test.sv ----
`timescale 1ns/1ps
module ampcsb_bank_test;
  import ampcsb_pkg::*;
  localparam int         LIMIT    = 60000;
  localparam logic [6:0] DEV_ADDR = ADDR_BASE;
  // Address strap on code 3, mode strap on code 2
  localparam logic [6:0] STRAP_ADDR = 7'h32;

  logic        clk, reset_n, sclIn, sdaDrive, sdaLine, sdaOe, sdaOut, busMode, ampOn, muteAll;
  logic        offsetDiagOn, offsetProtectOn, oscPlusTen, freqHopOn, thermalDiagOn, warnAt120;
  logic        acLoadDetOn, dcLoadDetOn, clipAtTen, shortAtTwoOhm, diagOut, diagOe;
  logic [1:0]  slavePhase, adsStrap, modStrap;
  logic [3:0]  chanEnable, offsetMonitorOn, clipToDiag;
  logic [29:0] stim;
  logic [31:0] cfg1Pack, cfg2Pack, cfg3Pack;
  int          err_count, tests_run, cycles;

  // Pull-up on the data wire
  assign sdaLine  = sdaDrive & !(sdaOe && !sdaOut);
  assign cfg1Pack = {24'h0, offsetDiagOn, offsetMonitorOn[0], clipToDiag[0], freqHopOn, oscPlusTen,
                     acLoadDetOn, chanEnable[0], ampOn};
  assign cfg2Pack = {24'h0, offsetProtectOn, offsetMonitorOn[1], clipToDiag[1], thermalDiagOn, warnAt120,
                     dcLoadDetOn, chanEnable[1], muteAll};
  assign cfg3Pack = {24'h0, offsetMonitorOn[2], clipToDiag[2], clipAtTen, shortAtTwoOhm, chanEnable[2],
                     offsetMonitorOn[3], clipToDiag[3], chanEnable[3]};

  ampcsb_i2c_master bus (.sclOut(sclIn), .sdaDrive(sdaDrive), .sdaLine(sdaLine));

  ampcsb_bank dut
  (
    .clk (clk), .reset_n (reset_n), .sclIn (sclIn), .sdaIn (sdaLine), .sdaOut (sdaOut), .sdaOe (sdaOe),
    .address_strap_a (adsStrap), .modeStrap (modStrap),
    .shortGnd (stim[3:0]), .shortSupply (stim[7:4]), .openLoad (stim[11:8]), .shortedLoad (stim[15:12]),
    .clipActive (stim[19:16]), .dcLoadValid (stim[20]), .offsetDetected (stim[21]), .pllLocked (stim[22]),
    .clockFailure (stim[23]), .startupBusy (stim[24]), .overTemp (stim[25]), .tempWarn (stim[26]),
    .undervoltage_flag (stim[27]), .overvoltage_flag (stim[28]), .acLoadHit (stim[29]),
    .busMode (busMode), .ampOn (ampOn), .muteAll (muteAll), .chanEnable (chanEnable),
    .offsetMonitorOn (offsetMonitorOn), .clipToDiag (clipToDiag), .offsetDiagOn (offsetDiagOn),
    .offsetProtectOn (offsetProtectOn), .oscPlusTen (oscPlusTen), .freqHopOn (freqHopOn),
    .thermalDiagOn (thermalDiagOn), .warnAt120 (warnAt120), .acLoadDetOn (acLoadDetOn),
    .dcLoadDetOn (dcLoadDetOn), .clipAtTen (clipAtTen), .shortAtTwoOhm (shortAtTwoOhm),
    .slavePhase (slavePhase), .diagnostic_pinOut (diagOut), .diagnostic_pinOe (diagOe)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    tests_run++;
    if (seen !== expected)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, expected, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic writeCfg(input logic [31:0] cfg);
    logic [7:0] rx;
    logic       ack;
    bus.startCond();
    bus.xfer({DEV_ADDR, 1'b0}, 1'b1, rx, ack);
    check("write address ack", {31'h0, ack}, 32'h0);
    for (int i = 3; i >= 0; i--)
    begin
      bus.xfer(cfg[8*i +: 8], 1'b1, rx, ack);
      check("config byte ack", {31'h0, ack}, 32'h0);
    end
    bus.xfer(8'h00, 1'b1, rx, ack);
    check("fifth byte refused", {31'h0, ack}, 32'h1);
    bus.stopCond();
  endtask

  task automatic readStat(output logic [31:0] st);
    logic [7:0] rx;
    logic       ack;
    bus.startCond();
    bus.xfer({DEV_ADDR, 1'b1}, 1'b1, rx, ack);
    check("read address ack", {31'h0, ack}, 32'h0);
    for (int i = 3; i >= 0; i--)
    begin
      bus.xfer(8'hFF, i == 0, rx, ack);
      st[8*i +: 8] = rx;
    end
    bus.stopCond();
  endtask

  task automatic testReset();
    logic [7:0]  rx;
    logic        ack;
    logic [31:0] st;
    check("cfg1 decode", cfg1Pack, 32'hE2);
    check("cfg2 decode", cfg2Pack, 32'hF2);
    check("cfg3 decode", cfg3Pack, 32'hCF);
    check("bus mode", {31'h0, busMode}, 32'h1);
    check("diagnostic_pin after reset", {31'h0, diagOe}, 32'h1);
    bus.startCond();
    bus.xfer({DEV_ADDR + 7'h01, 1'b0}, 1'b1, rx, ack);
    check("foreign address", {31'h0, ack}, 32'h1);
    bus.stopCond();
    readStat(st);
    check("status after reset", st, 32'h80000000);
  endtask

  task automatic testWrite();
    logic [1:0] ph;
    for (int k = 0; k < 4; k++)
    begin
      ph = k[1:0];
      writeCfg({8'h9D, 8'h7F, 8'h58, 2'h0, 2'h2, ph, 2'h0});
      check("cfg1 decode", cfg1Pack, 32'h7F);
      check("cfg2 decode", cfg2Pack, 32'h8D);
      check("cfg3 decode", cfg3Pack, 32'h7D);
      check("slave phase", {30'h0, slavePhase}, {30'h0, ph});
      check("diagnostic_pin released", {31'h0, diagOe}, 32'h0);
    end
  endtask

  task automatic testRead();
    logic [31:0] st;
    @(negedge clk) stim = 30'h3FFF8421;
    repeat (6) @(negedge clk);
    check("diagnostic_pin on faults", {31'h0, diagOe}, 32'h1);
    stim = 30'h00108400;
    repeat (6) @(negedge clk);
    check("diagnostic_pin follows faults", {31'h0, diagOe}, 32'h0);
    readStat(st);
    check("latched status", st, 32'h65E6140C);
    readStat(st);
    check("status after read", st, 32'h40001008);
    check("diagnostic_pin cleared", {31'h0, diagOe}, 32'h0);
  endtask

  // Mid-run reset with new straps: other address, then grounded strap
  task automatic testStraps();
    logic [7:0] rx;
    logic       ack;
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk) reset_n = 1'b0;
      adsStrap = (k == 0) ? 2'h3 : 2'h0;
      modStrap = 2'h2;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      repeat (30) @(negedge clk);
      check("strap bus mode", {31'h0, busMode}, {31'h0, k == 0});
      check("cfg1 after reset", cfg1Pack, 32'hE2);
      bus.startCond();
      bus.xfer({STRAP_ADDR, 1'b0}, 1'b1, rx, ack);
      check("strap address ack", {31'h0, ack}, {31'h0, k != 0});
      bus.stopCond();
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    reset_n   = 1'b0;
    stim      = '0;
    adsStrap  = 2'h1;
    modStrap  = 2'h0;
    err_count = 0;
    tests_run = 0;
    cycles    = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    repeat (30) @(negedge clk);
    testReset();
    testWrite();
    testRead();
    testStraps();
    final_report();
  end
endmodule
